// *** acc_consts.vh ***
// register offsets, field positions, codes and reset values of the conversion control block
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

`define ACC_ADDR_W 3
`define ACC_DATA_W 8
`define ACC_RES_W 12

`define ACC_OFF_CONV_CTRL_STATUS 3'h0
`define ACC_OFF_TRIGGER_COMPARE_CTRL 3'h1
`define ACC_OFF_RESULT_HIGH 3'h2
`define ACC_OFF_RESULT_LOW 3'h3
`define ACC_OFF_COMPARE_VALUE_HIGH 3'h4
`define ACC_OFF_COMPARE_VALUE_LOW 3'h5
`define ACC_OFF_RESOLUTION_CFG 3'h6

`define ACC_BIT_DONE_FLAG 7
`define ACC_BIT_DONE_IRQ_ENABLE 6
`define ACC_BIT_CONTINUOUS_ENABLE 5
`define ACC_SEL_HI 4
`define ACC_SEL_LO 0

`define ACC_BIT_ACTIVE_FLAG 7
`define ACC_BIT_TRIGGER_SELECT 6
`define ACC_BIT_COMPARE_ENABLE 5
`define ACC_BIT_COMPARE_GE_SELECT 4

`define ACC_MODE_HI 3
`define ACC_MODE_LO 2

`define ACC_SEL_OFF 5'h1F
`define ACC_SEL_RESET 5'h1F

`define ACC_MODE_8BIT 2'h0
`define ACC_MODE_12BIT 2'h1
`define ACC_MODE_10BIT 2'h2

`define ACC_MASK_8BIT 12'h0FF
`define ACC_MASK_10BIT 12'h3FF
`define ACC_MASK_12BIT 12'hFFF

`define ACC_BYTE_ZERO 8'h00
`define ACC_RES_ZERO 12'h000
`define ACC_RES_ONE 12'h001
`define ACC_CVH_W 4

`endif

// *** acc_conv_ctrl.v ***
// control and status logic of a successive-approximation converter
`timescale 1ns/10ps
`include "acc_consts.vh"

module acc_conv_ctrl (
  input wire clock_i,
  input wire rstn_i,
  input wire [`ACC_ADDR_W-1:0] addr_i,
  input wire [`ACC_DATA_W-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`ACC_DATA_W-1:0] rdata_o,
  input wire hw_trigger_in_i,
  input wire core_done_i,
  input wire [`ACC_RES_W-1:0] core_result_i,
  output reg core_start_o,
  output reg core_abort_o,
  output reg core_enable_o,
  output reg [`ACC_SEL_HI:`ACC_SEL_LO] core_channel_o,
  output reg [1:0] core_mode_o,
  output reg irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg done_flag;
  reg done_irq_enable;
  reg continuous_enable;
  reg active_flag;
  reg trigger_select;
  reg compare_enable;
  reg compare_ge_select;
  reg [`ACC_DATA_W-1:0] result_high;
  reg [`ACC_DATA_W-1:0] result_low;
  reg [`ACC_CVH_W-1:0] compare_value_high;
  reg [`ACC_DATA_W-1:0] compare_value_low;
  reg read_lock;

  // resolution mask shared by result formatting and compare value
  function [`ACC_RES_W-1:0] res_mask;
    input [1:0] mode;
    begin
      case (mode)
        `ACC_MODE_8BIT: res_mask = `ACC_MASK_8BIT;
        `ACC_MODE_10BIT: res_mask = `ACC_MASK_10BIT;
        default: res_mask = `ACC_MASK_12BIT;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode and datapath

  wire wr_ctrl = wr_i && (addr_i == `ACC_OFF_CONV_CTRL_STATUS);
  wire wr_trig = wr_i && (addr_i == `ACC_OFF_TRIGGER_COMPARE_CTRL);
  wire wr_cvh = wr_i && (addr_i == `ACC_OFF_COMPARE_VALUE_HIGH);
  wire wr_cvl = wr_i && (addr_i == `ACC_OFF_COMPARE_VALUE_LOW);
  wire wr_cfg = wr_i && (addr_i == `ACC_OFF_RESOLUTION_CFG);
  wire rd_high = rd_i && (addr_i == `ACC_OFF_RESULT_HIGH);
  wire rd_low = rd_i && (addr_i == `ACC_OFF_RESULT_LOW);

  wire [`ACC_SEL_HI:`ACC_SEL_LO] wsel = wdata_i[`ACC_SEL_HI:`ACC_SEL_LO];
  wire wsel_off = (wsel == `ACC_SEL_OFF);
  wire sel_off = (core_channel_o == `ACC_SEL_OFF);
  wire is_8bit = (core_mode_o == `ACC_MODE_8BIT);

  wire [`ACC_RES_W-1:0] mask = res_mask(core_mode_o);
  wire [`ACC_RES_W-1:0] res_val = core_result_i & mask;
  // compare high contributes only above bit 7, masked away in 8-bit mode
  wire [`ACC_RES_W-1:0] cmp_val = {compare_value_high, compare_value_low} & mask;
  wire [`ACC_RES_W-1:0] cmp_twos = (~cmp_val) + `ACC_RES_ONE;
  wire [`ACC_RES_W-1:0] diff_val = (res_val + cmp_twos) & mask;
  wire cmp_true = compare_ge_select ? (res_val >= cmp_val) : (res_val < cmp_val);
  wire accept = !compare_enable || cmp_true;
  wire [`ACC_RES_W-1:0] store_val = compare_enable ? diff_val : res_val;

  // a write to main control aborts, so a done in that same cycle is dropped
  wire finish = core_done_i && active_flag && !wr_ctrl;
  wire lock_eff = read_lock && !is_8bit;
  wire load_res = finish && accept && !lock_eff;
  wire set_done = finish && accept;
  wire hw_start = trigger_select && hw_trigger_in_i && !sel_off && !active_flag
    && !wr_ctrl;
  wire restart = finish && continuous_enable && !sel_off;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      done_irq_enable <= 1'b0;
      continuous_enable <= 1'b0;
      core_channel_o <= `ACC_SEL_RESET;
      active_flag <= 1'b0;
      core_enable_o <= 1'b0;
      core_start_o <= 1'b0;
      core_abort_o <= 1'b0;
    end else begin
      core_start_o <= 1'b0;
      core_abort_o <= 1'b0;
      if (wr_ctrl) begin
        done_irq_enable <= wdata_i[`ACC_BIT_DONE_IRQ_ENABLE];
        continuous_enable <= wdata_i[`ACC_BIT_CONTINUOUS_ENABLE];
        core_channel_o <= wsel;
        core_abort_o <= active_flag;
        if (!wsel_off && !trigger_select) begin
          active_flag <= 1'b1;
          core_enable_o <= 1'b1;
          core_start_o <= 1'b1;
        end else begin
          active_flag <= 1'b0;
          core_enable_o <= 1'b0;
        end
      end else if (hw_start) begin
        active_flag <= 1'b1;
        core_enable_o <= 1'b1;
        core_start_o <= 1'b1;
      end else if (finish) begin
        if (restart) begin
          core_start_o <= 1'b1;
        end else begin
          active_flag <= 1'b0;
          core_enable_o <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, results and configuration

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      done_flag <= 1'b0;
      irq_o <= 1'b0;
      trigger_select <= 1'b0;
      compare_enable <= 1'b0;
      compare_ge_select <= 1'b0;
      compare_value_high <= {`ACC_CVH_W{1'b0}};
      compare_value_low <= `ACC_BYTE_ZERO;
      core_mode_o <= `ACC_MODE_8BIT;
      result_high <= `ACC_BYTE_ZERO;
      result_low <= `ACC_BYTE_ZERO;
      read_lock <= 1'b0;
    end else begin
      // set wins over the low-result read clear
      if (set_done) begin
        done_flag <= 1'b1;
      end else if (wr_ctrl || rd_low) begin
        done_flag <= 1'b0;
      end
      irq_o <= (set_done || (done_flag && !wr_ctrl && !rd_low))
        && (wr_ctrl ? wdata_i[`ACC_BIT_DONE_IRQ_ENABLE] : done_irq_enable);
      if (wr_trig) begin
        trigger_select <= wdata_i[`ACC_BIT_TRIGGER_SELECT];
        compare_enable <= wdata_i[`ACC_BIT_COMPARE_ENABLE];
        compare_ge_select <= wdata_i[`ACC_BIT_COMPARE_GE_SELECT];
      end
      if (wr_cvh) begin
        compare_value_high <= wdata_i[`ACC_CVH_W-1:0];
      end
      if (wr_cvl) begin
        compare_value_low <= wdata_i;
      end
      if (wr_cfg) begin
        core_mode_o <= wdata_i[`ACC_MODE_HI:`ACC_MODE_LO];
      end
      if (load_res) begin
        // mask already clears the unused upper result bits
        result_high <= {{(`ACC_DATA_W-`ACC_CVH_W){1'b0}},
          store_val[`ACC_RES_W-1:`ACC_DATA_W]};
        result_low <= store_val[`ACC_DATA_W-1:0];
      end
      // a low read releases the lock even if a high read never came
      if (rd_low) begin
        read_lock <= 1'b0;
      end else if (rd_high && !is_8bit) begin
        read_lock <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_o <= `ACC_BYTE_ZERO;
    end else if (rd_i) begin
      case (addr_i)
        `ACC_OFF_CONV_CTRL_STATUS:
          rdata_o <= {done_flag, done_irq_enable, continuous_enable, core_channel_o};
        `ACC_OFF_TRIGGER_COMPARE_CTRL:
          rdata_o <= {active_flag, trigger_select, compare_enable, compare_ge_select,
            4'h0};
        `ACC_OFF_RESULT_HIGH: rdata_o <= result_high;
        `ACC_OFF_RESULT_LOW: rdata_o <= result_low;
        `ACC_OFF_COMPARE_VALUE_HIGH:
          rdata_o <= {{(`ACC_DATA_W-`ACC_CVH_W){1'b0}}, compare_value_high};
        `ACC_OFF_COMPARE_VALUE_LOW: rdata_o <= compare_value_low;
        `ACC_OFF_RESOLUTION_CFG: rdata_o <= {4'h0, core_mode_o, 2'h0};
        default: rdata_o <= `ACC_BYTE_ZERO;
      endcase
    end else begin
      rdata_o <= `ACC_BYTE_ZERO;
    end
  end

endmodule

// *** acc_monitor.sv ***
// port assertions for the conversion control block
`timescale 1ns/10ps
module acc_monitor (
  input wire clock_i,
  input wire rstn_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire hw_trigger_in_i,
  input wire core_done_i,
  input wire core_start_o,
  input wire core_abort_o,
  input wire core_enable_o,
  input wire [4:0] core_channel_o,
  input wire [1:0] core_mode_o
);
  // shadow bits, the checker cannot see the registers
  reg trig;
  reg cont;
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      trig <= 1'b0;
      cont <= 1'b0;
    end else begin
      if (wr_i && addr_i == 3'h1) trig <= wdata_i[6];
      if (wr_i && addr_i == 3'h0) cont <= wdata_i[5];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wr;
    wr_i && addr_i == 3'h0;
  endsequence
  sequence s_done;
    core_done_i && core_enable_o && !(wr_i && addr_i == 3'h0);
  endsequence
  chk_sw_start: assert property (s_wr ##0 (wdata_i[4:0] != 5'h1F && !trig) |=>
    core_start_o && core_enable_o) else $error("no start after write");
  chk_sel_off: assert property (s_wr ##0 wdata_i[4:0] == 5'h1F |=>
    !core_start_o && !core_enable_o) else $error("off code started");
  chk_abort_run: assert property (s_wr ##0 core_enable_o |=> core_abort_o)
    else $error("no abort");
  chk_chan_load: assert property (s_wr |=> core_channel_o == $past(wdata_i[4:0]))
    else $error("selector wrong");
  chk_single_end: assert property (s_done ##0 !cont |=> !core_enable_o && !core_start_o)
    else $error("no power down");
  chk_cont_restart: assert property (s_done ##0 cont |=> core_start_o)
    else $error("no restart");
  chk_hw_start: assert property (hw_trigger_in_i && trig && !core_enable_o && !wr_i
    && core_channel_o != 5'h1F |=> core_start_o) else $error("trigger lost");
  chk_sw_only: assert property (hw_trigger_in_i && !trig && !core_enable_o && !wr_i
    |=> !core_start_o) else $error("trigger not ignored");
  chk_mode_load: assert property (wr_i && addr_i == 3'h6 && wdata_i[3:2] != 2'h3
    |=> core_mode_o == $past(wdata_i[3:2])) else $error("mode wrong");
endmodule

// *** testbench.sv ***
// register level bench for the conversion control block
`timescale 1ns/10ps
module testbench;
  reg clock_i = 1'b0;
  reg rstn_i = 1'b0;
  reg [2:0] addr_i = 3'h0;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg hw_trigger_in_i = 1'b0;
  reg core_done_i = 1'b0;
  reg [11:0] core_result_i = 12'h000;
  wire [7:0] rdata_o;
  wire core_start_o, core_abort_o, core_enable_o, irq_o;
  wire [4:0] core_channel_o;
  wire [1:0] core_mode_o;
  integer fail_count = 0;
  integer n_checks = 0;
  integer m;
  reg [11:0] e;
  always #2 clock_i = ~clock_i;
  acc_conv_ctrl uut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hw_trigger_in_i(hw_trigger_in_i),
    .core_done_i(core_done_i), .core_result_i(core_result_i), .core_start_o(core_start_o),
    .core_abort_o(core_abort_o), .core_enable_o(core_enable_o),
    .core_channel_o(core_channel_o), .core_mode_o(core_mode_o), .irq_o(irq_o));
  task check(input [7:0] seen, input [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [2:0] a, input [7:0] x);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    check(rdata_o, x);
  endtask
  // core side: one done strobe with its result
  task fin(input [11:0] r);
    @(posedge clock_i);
    core_done_i <= 1'b1;
    core_result_i <= r;
    @(posedge clock_i);
    core_done_i <= 1'b0;
  endtask
  task conv(input [7:0] c, input [11:0] r);
    wr(3'h0, c);
    fin(r);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count = fail_count + 1;
    final_report;
  end
  initial begin
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    for (m = 0; m < 8; m = m + 1) rd(m[2:0], m == 0 ? 8'h1F : 8'h00);
    $display("test reset done");
    for (m = 0; m < 3; m = m + 1) begin
      e = 12'hABC & (m == 0 ? 12'h0FF : m == 1 ? 12'hFFF : 12'h3FF);
      wr(3'h6, {4'h0, m[1:0], 2'h0});
      @(negedge clock_i);
      check(core_mode_o, {6'h00, m[1:0]});
      conv(8'h45, 12'hABC);
      repeat (2) @(negedge clock_i);
      check(irq_o, 1'b1);
      rd(3'h0, 8'hC5);
      rd(3'h2, {4'h0, e[11:8]});
      rd(3'h3, e[7:0]);
      rd(3'h0, 8'h45);
      check(irq_o, 1'b0);
    end
    $display("test modes done");
    wr(3'h6, 8'h04);
    wr(3'h4, 8'h01);
    wr(3'h1, 8'h30);
    conv(8'h05, 12'h0FF);
    rd(3'h0, 8'h05);
    rd(3'h3, 8'hBC);
    conv(8'h05, 12'h180);
    rd(3'h0, 8'h85);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h80);
    wr(3'h1, 8'h20);
    conv(8'h05, 12'h0FF);
    rd(3'h2, 8'h0F);
    rd(3'h3, 8'hFF);
    wr(3'h6, 8'h00);
    wr(3'h5, 8'h80);
    wr(3'h1, 8'h30);
    conv(8'h05, 12'h0C0);
    rd(3'h3, 8'h40);
    wr(3'h1, 8'h00);
    $display("test compare done");
    conv(8'h05, 12'h044);
    rd(3'h2, 8'h00);
    conv(8'h05, 12'h055);
    rd(3'h3, 8'h55);
    wr(3'h6, 8'h04);
    conv(8'h05, 12'h111);
    rd(3'h2, 8'h01);
    conv(8'h05, 12'h222);
    rd(3'h3, 8'h11);
    conv(8'h05, 12'h333);
    rd(3'h2, 8'h03);
    rd(3'h3, 8'h33);
    $display("test interlock done");
    conv(8'h25, 12'h001);
    rd(3'h1, 8'h80);
    rd(3'h3, 8'h01);
    wr(3'h0, 8'h1F);
    @(negedge clock_i);
    check(core_abort_o, 1'b1);
    check({3'h0, core_channel_o}, 8'h1F);
    rd(3'h1, 8'h00);
    check(core_enable_o, 1'b0);
    $display("test continuous done");
    wr(3'h1, 8'h40);
    wr(3'h0, 8'h07);
    rd(3'h1, 8'h40);
    @(posedge clock_i);
    hw_trigger_in_i <= 1'b1;
    @(posedge clock_i);
    hw_trigger_in_i <= 1'b0;
    @(negedge clock_i);
    check(core_start_o, 1'b1);
    rd(3'h1, 8'hC0);
    fin(12'h077);
    rd(3'h1, 8'h40);
    rd(3'h3, 8'h77);
    $display("test trigger done");
    final_report;
  end
endmodule
bind acc_conv_ctrl acc_monitor u_mon (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .hw_trigger_in_i(hw_trigger_in_i),
  .core_done_i(core_done_i), .core_start_o(core_start_o), .core_abort_o(core_abort_o),
  .core_enable_o(core_enable_o), .core_channel_o(core_channel_o), .core_mode_o(core_mode_o));
